// ### rtl/bwdt_defs.svh
// constants for the board watchdog: jumper codes and timeout figures
// assumes a 100 MHz clock and synchronous jumper and bus inputs
`ifndef BWDT_DEFS_SVH
`define BWDT_DEFS_SVH

`define BWDT_CLK_MHZ 100
`define BWDT_TMO_LONG_MS 1200
`define BWDT_TMO_MID_MS 600
`define BWDT_TMO_SHORT_MS 150
`define BWDT_MS_CYCLES (`BWDT_CLK_MHZ * 1000)
`define BWDT_TMO_LONG_CYC (`BWDT_TMO_LONG_MS * `BWDT_MS_CYCLES)
`define BWDT_TMO_MID_CYC (`BWDT_TMO_MID_MS * `BWDT_MS_CYCLES)
`define BWDT_TMO_SHORT_CYC (`BWDT_TMO_SHORT_MS * `BWDT_MS_CYCLES)
`define BWDT_RST_PULSE_CYC 16
`define BWDT_SEL_LONG 2'h0
`define BWDT_SEL_MID 2'h1
`define BWDT_SEL_SHORT 2'h2
`define BWDT_MODE_HW 2'h0
`define BWDT_MODE_OFF 2'h1
`define BWDT_MODE_SW 2'h2

`endif

// ### rtl/bwdt_pkg.sv
// types for the board watchdog
// assumes bwdt_defs.svh is on the include path
package bwdt_pkg;
  typedef enum logic [1:0] {
    BWDT_ST_IDLE = 2'b00,
    BWDT_ST_WATCH = 2'b01,
    BWDT_ST_RESET = 2'b10
  } bwdt_state_e;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] tsel;
  } bwdt_jumper_s;
endpackage

// ### rtl/bwdt_limit.sv
// timeout limit lookup for the board watchdog
// assumes the jumper code is stable and synchronous
`timescale 1ns/10ps
`include "bwdt_defs.svh"
module bwdt_limit #(
  parameter int CW = 28,
  parameter logic [CW-1:0] LIM_LONG = CW'(`BWDT_TMO_LONG_CYC),
  parameter logic [CW-1:0] LIM_MID = CW'(`BWDT_TMO_MID_CYC),
  parameter logic [CW-1:0] LIM_SHORT = CW'(`BWDT_TMO_SHORT_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // jumper code in, registered limit out
  input wire logic [1:0] tsel,
  output logic [CW-1:0] limit
);
  // decode of the timeout jumper
  wire logic [CW-1:0] limit_nxt;
  assign limit_nxt = (tsel == `BWDT_SEL_MID) ? LIM_MID :
                     (tsel == `BWDT_SEL_SHORT) ? LIM_SHORT : LIM_LONG;

  // registered lookup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) limit <= LIM_LONG;
    else limit <= limit_nxt;
  end
endmodule

// ### rtl/bwdt_top.sv
// board watchdog: restarts on bus latch activity or software access
// assumes jumpers, bus latch enable and access strobe are synchronous to clk
// Operation
// - three jumper modes: hardware, software, disabled
// - timeout jumper picks 1200, 600 or 150 ms
// - hardware mode resets board when bus latch stalls
// - software mode resets board without periodic access
`timescale 1ns/10ps
`include "bwdt_defs.svh"
module bwdt_top
  import bwdt_pkg::*;
#(
  parameter int CW = 28,
  parameter logic [CW-1:0] LIM_LONG = CW'(`BWDT_TMO_LONG_CYC),
  parameter logic [CW-1:0] LIM_MID = CW'(`BWDT_TMO_MID_CYC),
  parameter logic [CW-1:0] LIM_SHORT = CW'(`BWDT_TMO_SHORT_CYC),
  parameter int PULSE = `BWDT_RST_PULSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // jumpers
  input wire logic [1:0] mode_select_jumper,
  input wire logic [1:0] timeout_select_jumper,
  // watched activity
  input wire logic bale,
  input wire logic sw_access,
  // board reset and state out
  output logic board_reset,
  output logic [1:0] wd_state
);
  // ****************************************
  // jumper decode and activity detection
  // ****************************************
  bwdt_jumper_s jmp;
  logic bale_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [7:0] pul_r;
  bwdt_state_e st_r;
  bwdt_state_e st_nxt;
  logic [CW-1:0] limit;

  assign jmp = '{mode: mode_select_jumper, tsel: timeout_select_jumper};

  // jumper code compare shared by both supervision modes
  function automatic logic mode_is(input logic [1:0] code, input logic [1:0] want);
    return (code == want);
  endfunction

  // mode decode; code 3 and the disabled code both leave the watchdog idle
  wire logic mode_hw = mode_is(jmp.mode, `BWDT_MODE_HW);
  wire logic mode_sw = mode_is(jmp.mode, `BWDT_MODE_SW);
  wire logic mode_on = mode_hw | mode_sw;
  // any edge of the latch enable counts as toggling
  wire logic bale_edge = bale ^ bale_r;
  wire logic kick = (mode_hw & bale_edge) | (mode_sw & sw_access);
  wire logic expired = (cnt_r >= limit - CW'(1));

  // timeout limit from the second jumper
  bwdt_limit #(
    .CW(CW),
    .LIM_LONG(LIM_LONG),
    .LIM_MID(LIM_MID),
    .LIM_SHORT(LIM_SHORT)
  ) u_limit (
    .clk(clk),
    .rst(rst),
    .tsel(jmp.tsel),
    .limit(limit)
  );

  // ****************************************
  // supervision state machine
  // ****************************************
  // the count restarts on activity, runs out into a pulse, then idles a cycle
  // jumpers are levels; a change to disabled drops the count at once
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      BWDT_ST_IDLE: begin
        cnt_nxt = '0;
        if (mode_on) st_nxt = BWDT_ST_WATCH;
      end
      BWDT_ST_WATCH: begin
        if (!mode_on) begin
          st_nxt = BWDT_ST_IDLE;
          cnt_nxt = '0;
        end else if (kick) begin
          cnt_nxt = '0;
        end else if (expired) begin
          st_nxt = BWDT_ST_RESET;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      BWDT_ST_RESET: begin
        cnt_nxt = '0;
        if (pul_r == 8'(PULSE - 1)) st_nxt = BWDT_ST_IDLE;
      end
      default: begin
        st_nxt = BWDT_ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  // state, counter and edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= BWDT_ST_IDLE;
      cnt_r <= '0;
      bale_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bale_r <= bale;
    end
  end

  // reset pulse length counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pul_r <= 8'h00;
    else if (st_r == BWDT_ST_RESET) pul_r <= pul_r + 8'h01;
    else pul_r <= 8'h00;
  end

  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      board_reset <= 1'b0;
      wd_state <= 2'h0;
    end else begin
      board_reset <= (st_nxt == BWDT_ST_RESET);
      wd_state <= st_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // pulse length seen on the output, for the width checks
  logic [7:0] pulse_seen_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pulse_seen_r <= 8'h00;
    else if (board_reset) pulse_seen_r <= pulse_seen_r + 8'h01;
    else pulse_seen_r <= 8'h00;
  end

  // disabled jumper: no reset pulse may start
  chk_off_no_reset: assert property (@(posedge clk) disable iff (rst)
    (!mode_on && st_r != BWDT_ST_RESET) |=> !board_reset)
    else $error("reset raised while watchdog disabled");

  // any qualifying activity restarts the count
  chk_kick_clears: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_WATCH && mode_on && kick) |=> (cnt_r == '0))
    else $error("activity did not restart count");

  // bus latch edge restarts the count in hardware mode
  chk_hw_bale_kick: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_WATCH && mode_hw && bale_edge) |=> (cnt_r == '0))
    else $error("bus latch edge did not restart count");

  // access strobe restarts the count in software mode
  chk_sw_kick: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_WATCH && mode_sw && sw_access) |=> (cnt_r == '0))
    else $error("software access did not restart count");

  // quiet watch cycles advance the count by one
  chk_count_step: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_WATCH && mode_on && !kick && !expired) |=>
      (cnt_r == $past(cnt_r) + CW'(1)))
    else $error("watch count did not advance");

  // last quiet cycle starts the pulse
  chk_expire_reset: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_WATCH && mode_on && !kick && expired) |=> board_reset)
    else $error("timeout did not reset board");

  // pulse holds until its own counter ends
  chk_pulse_hold: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_RESET && pul_r != 8'(PULSE - 1)) |=> board_reset)
    else $error("board reset pulse dropped early");

  // a finished pulse lasted exactly PULSE cycles
  chk_pulse_len: assert property (@(posedge clk) disable iff (rst)
    $fell(board_reset) |-> (pulse_seen_r == 8'(PULSE)))
    else $error("board reset pulse has wrong length");

  // a pulse never outgrows PULSE cycles
  chk_pulse_cap: assert property (@(posedge clk) disable iff (rst)
    (pulse_seen_r <= 8'(PULSE)))
    else $error("board reset pulse too long");

  // pulse end passes through idle before watching again
  chk_pulse_rearm: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_RESET && pul_r == 8'(PULSE - 1)) |=> (wd_state == 2'(BWDT_ST_IDLE)))
    else $error("pulse did not return to idle");

  // no pulse before the full timeout
  chk_no_early: assert property (@(posedge clk) disable iff (rst)
    $rose(board_reset) |-> $past(cnt_r) >= limit - CW'(1))
    else $error("board reset before timeout");

  // outside a pulse, the disabled jumper forces idle on the next edge
  chk_off_idle: assert property (@(posedge clk) disable iff (rst)
    (!mode_on && st_r != BWDT_ST_RESET) |=> (wd_state == 2'(BWDT_ST_IDLE)))
    else $error("disabled watchdog left idle");

  // timeout jumper reaches the limit one edge later
  chk_limit_short: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_WATCH && jmp.tsel == `BWDT_SEL_SHORT) |=> (limit == LIM_SHORT))
    else $error("short timeout not selected");
  chk_limit_mid: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_WATCH && jmp.tsel == `BWDT_SEL_MID) |=> (limit == LIM_MID))
    else $error("middle timeout not selected");
  chk_limit_long: assert property (@(posedge clk) disable iff (rst)
    (st_r == BWDT_ST_WATCH && jmp.tsel != `BWDT_SEL_SHORT && jmp.tsel != `BWDT_SEL_MID) |=>
      (limit == LIM_LONG))
    else $error("long timeout not selected");
endmodule

// ### verif/bwdt_host.sv
// host side model: bus latch toggling or software access strobes
// assumes act and gap change only at clk rising edges
`timescale 1ns/10ps
module bwdt_host (
  // clock
  input wire logic clk,
  // activity kind 1 bus, 2 software; kick spacing in cycles
  input wire logic [1:0] act,
  input wire logic [7:0] gap,
  // activity out
  output logic bale,
  output logic sw_access
);
  int n = 0;
  initial begin
    bale = 1'b0;
    sw_access = 1'b0;
  end
  // one kick every gap cycles, always inside the timeout
  always @(posedge clk) begin
    n = (n + 1 >= gap) ? 0 : n + 1;
    if (act == 2'h1 && n == 0) bale <= ~bale;
    sw_access <= (act == 2'h2 && n == 0);
  end
endmodule

// ### verif/testbench.sv
// bench: integer model of kick-to-reset delay, checked at every reset
// assumes shortened limits 40/20/10 cycles and a 16 cycle pulse
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rst = 1, bale, sw_access, board_reset, prev = 0;
  logic [1:0] wd_state, mode = 0, tsel = 0, act = 0;
  logic [7:0] gap = 8'h05;
  logic [31:0] lf = 32'h3F38;
  int n_errors = 0, comparisons = 0, since = 0, hi = 0, rises = 0, lim = 40, cyc = 0, blk = 0;
  always #5 clk = ~clk;
  bwdt_host i_bwdt_host (.clk(clk), .act(act), .gap(gap), .bale(bale), .sw_access(sw_access));
  bwdt_top #(.LIM_LONG(28'h28), .LIM_MID(28'h14), .LIM_SHORT(28'h0A)) i_bwdt_top (
    .clk(clk), .rst(rst), .mode_select_jumper(mode), .timeout_select_jumper(tsel),
    .bale(bale), .sw_access(sw_access), .board_reset(board_reset), .wd_state(wd_state));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // run limit: a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_errors++;
      results();
    end
  end
  // model: cycles since last kick; reset, pulse and idle cycles blank it
  always @(posedge clk) begin
    if (rst || mode[0]) begin
      since = 0;
      blk = 1;
    end else if (blk > 0) begin
      blk--;
      since = 0;
    end else if ((mode == 2'h0 && bale !== prev) || (mode == 2'h2 && sw_access === 1'b1)) begin
      since = 0;
    end else begin
      since++;
    end
    prev = bale;
    #1;
    if (board_reset === 1'b1) begin
      if (hi == 0) begin
        rises++;
        blk = 17;
        chk("delay", 32'(since), 32'(lim));
        chk("state", 32'(wd_state), 32'h2);
      end
      hi++;
    end else if (hi != 0) begin
      chk("pulse", 32'(hi), 32'h10);
      chk("rearm", 32'(wd_state), 32'h0);
      hi = 0;
    end
  end
  // one run: reset, kick for len cycles, then go quiet
  task automatic run(logic [1:0] m, logic [1:0] t, logic [1:0] a, int len);
    rst <= 1;
    mode <= m;
    tsel <= t;
    act <= a;
    lim = (t == 2'h1) ? 20 : (t == 2'h2) ? 10 : 40;
    lf = lfsr(lf);
    gap <= 8'(1 + lf % (lim - 2));
    rises = 0;
    repeat (3) @(posedge clk);
    rst <= 0;
    repeat (len) @(posedge clk);
    #1;
    chk("watch", 32'(wd_state), (m == 2'h0 || m == 2'h2) ? 32'h1 : 32'h0);
    @(posedge clk);
    act <= 0;
    repeat (lim + 18) @(posedge clk);
    chk("rises", 32'(rises), (m == 2'h0 || m == 2'h2) ? 32'h1 : 32'h0);
    $display("test mode %0h timeout %0h done", m, t);
  endtask
  initial begin
    run(2'h0, 2'h0, 2'h1, 150);
    run(2'h2, 2'h1, 2'h2, 150);
    run(2'h0, 2'h2, 2'h1, 80);
    run(2'h2, 2'h3, 2'h2, 100);
    run(2'h1, 2'h2, 2'h1, 60);
    run(2'h3, 2'h0, 2'h0, 60);
    results();
  end
endmodule
